// ---- hw_setup_pkg.sv ----
// constants, field layouts and carrier types for the hardware setup register bank
// assumes an APB master with 32-bit data; one register per aligned word
// Functional notes
// - encoder-ready and decoder-need flags go high when their events are pending.
// - phrase-queue-empty flag rises when the next phrase number is needed.
// - port-change flag is 1 only while an unmasked port input change is held.
// - driver selects: 0 gives open-drain pins, 1 gives push-pull pins.
// - flash-ready pull-up select is inverted: 0 enables the pull-up.
// - separate bits enable the auxiliary oscillator and the calendar clock.
// - converter clock source: 0 main oscillator, 1 external clock input.
// - sleep-state bit is read-only: 0 active, 1 in power-down.
// - port mode bits 7:6: 00 normal, 01 static, 10 multiplex, 11 reserved.
// - tracking bit enables clock tracking; rate bit picks 8 or 16 kHz sync.
// - master sync select: 0 converter frame sync, 1 external frame sync.
// - crystal bits 2:1 pick factor 5, 4.5 or 4; 11 reserved.
// - serial interface select: 0 time-division interface, 1 simple serial.
// - memory pin drive: 0 push-pull, 1 pull-up/down during reset and sleep.
// - transmit edge 0 rising/1 falling; receive edge 0 falling/1 rising.
// - refresh field: 64, 32, 16 or 8 kHz for codes 00 to 11.
// - slow crystal mode 1 assumes a 15.368 MHz crystal.
// - serial flash select routes memory data lines 0-7 to serial flash.
// - mixed-port bit turns address lines 8-11 into flash selects.
// - reset-affected registers reload defaults on reset or wake-up; others keep.
// - reading the event collect register clears it and the port-change flag.
package hw_setup_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_SETUP0 = 8'h04;
  localparam logic [7:0] ADDR_SETUP1 = 8'h08;
  localparam logic [7:0] ADDR_SETUP2 = 8'h0C;
  localparam logic [7:0] ADDR_SETUP3 = 8'h10;
  localparam logic [7:0] ADDR_EVENT = 8'h14;
  // status bit positions; status_view places the data flag at bit 3
  localparam int ST_PORT_CHANGE = 0;
  localparam int ST_PHRASE_EMPTY = 1;
  localparam int ST_DATA_FLAG = 2;
  // setup 0 positions
  localparam int S0_SLEEP = 0;
  localparam int S0_CONV_SRC = 1;
  localparam int S0_CALENDAR = 2;
  localparam int S0_AUX_CRYSTAL_FREQ_SEL = 3;
  localparam int S0_LINK_DRV = 4;
  localparam int S0_FLASH_PU = 5;
  localparam int S0_IRQ_DRV = 6;
  localparam int S0_SDX_DRV = 7;
  localparam logic [7:0] S0_WRITABLE = 8'hFE;
  localparam logic [7:0] S2_WRITABLE = 8'hE3;
  localparam logic [7:0] S3_WRITABLE = 8'h1C;
  // reset values
  localparam logic [7:0] SETUP0_RST = 8'h00;
  localparam logic [7:0] SETUP1_RST = 8'h00;
  localparam logic [7:0] SETUP2_RST = 8'h00;
  localparam logic [7:0] SETUP3_RST = 8'h00;
  localparam logic [15:0] EVENT_RST = 16'h0000;

  typedef enum logic [1:0] {PORT_NORMAL, PORT_STATIC, PORT_MUX, PORT_RSVD} port_mode_t;

  typedef struct packed {
    logic serial_out_drive_sel;
    logic irq_pin_drive_sel;
    logic flash_ready_pullup_off;
    logic serial_link_drive_sel;
    logic aux_crystal_enable;
    logic calendar_enable;
    logic conv_clk_src_sel;
    port_mode_t aux_port_mode;
    logic conv_clk_tracking;
    logic conv_rate_double;
    logic master_sync_sel;
    logic [1:0] crystal_freq_sel;
    logic alt_serial_sel;
    logic mem_pin_drive_sel;
    logic tx_edge_sel;
    logic rx_edge_sel;
    logic [1:0] refresh_rate;
    logic slow_crystal_mode;
    logic serial_flash_sel;
    logic mixed_port_sel;
  } hw_cfg_t;

  typedef struct packed {
    logic encoder_out_ready_flag;
    logic decoder_need_flag;
    logic phrase_queue_empty_flag;
    logic port_change_flag;
  } status_flags_t;
endpackage

// ---- hw_config_status_regs.sv ----
// APB register bank for device status and hardware setup
// assumes event inputs are synchronous pulses/levels on pclk
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module hw_config_status_regs (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device events
  input wire logic encoder_data_pending,
  input wire logic decoder_data_wanted,
  input wire logic phrase_wanted,
  input wire logic [15:0] port_match,
  input wire logic sleeping,
  input wire logic wake_up,
  // configuration outputs
  output hw_setup_pkg::hw_cfg_t cfg,
  output hw_setup_pkg::status_flags_t flags
);
  logic [7:0] hw_setup_zero;
  logic [7:0] hw_setup_one;
  logic [7:0] hw_setup_two;
  logic [7:0] hw_setup_three;
  logic [15:0] pin_event_collect;
  logic sleep_q;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_st = paddr == hw_setup_pkg::ADDR_STATUS;
  wire hit0 = paddr == hw_setup_pkg::ADDR_SETUP0;
  wire hit1 = paddr == hw_setup_pkg::ADDR_SETUP1;
  wire hit2 = paddr == hw_setup_pkg::ADDR_SETUP2;
  wire hit3 = paddr == hw_setup_pkg::ADDR_SETUP3;
  wire hit_ev = paddr == hw_setup_pkg::ADDR_EVENT;
  wire mapped = hit_st | hit0 | hit1 | hit2 | hit3 | hit_ev;
  // status and setup zero are read-only/mixed; writes to status are refused
  wire bad = !mapped || (pwrite && hit_st);
  wire ev_read = rd && hit_ev && !pready;
  wire [15:0] next_events = ev_read ? port_match : (pin_event_collect | port_match);
  wire [7:0] setup0_view = (hw_setup_zero & hw_setup_pkg::S0_WRITABLE) | {7'h00, sleep_q};
  wire [15:0] status_view = {12'h000, flags.encoder_out_ready_flag | flags.decoder_need_flag,
                             1'b0, flags.phrase_queue_empty_flag, flags.port_change_flag};
  wire [31:0] read_mux = hit_st ? {16'h0000, status_view} :
                         hit0 ? {24'h000000, setup0_view} :
                         hit1 ? {24'h000000, hw_setup_one} :
                         hit2 ? {24'h000000, hw_setup_two} :
                         hit3 ? {24'h000000, hw_setup_three} :
                         hit_ev ? {16'h0000, pin_event_collect} : 32'h0000_0000;
  wire wake_clear = wake_up;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && bad;
      prdata <= (rd && !pready && !bad) ? read_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_setup_zero <= hw_setup_pkg::SETUP0_RST;
      hw_setup_one <= hw_setup_pkg::SETUP1_RST;
      hw_setup_two <= hw_setup_pkg::SETUP2_RST;
      hw_setup_three <= hw_setup_pkg::SETUP3_RST;
    end else if (wake_clear) begin
      hw_setup_zero <= hw_setup_pkg::SETUP0_RST;
      hw_setup_one <= hw_setup_pkg::SETUP1_RST;
      hw_setup_two <= hw_setup_pkg::SETUP2_RST;
      hw_setup_three <= hw_setup_pkg::SETUP3_RST;
    end else if (wr && !pready) begin
      if (hit0) hw_setup_zero <= pwdata[7:0] & hw_setup_pkg::S0_WRITABLE;
      if (hit1) hw_setup_one <= pwdata[7:0];
      if (hit2) hw_setup_two <= pwdata[7:0] & hw_setup_pkg::S2_WRITABLE;
      if (hit3) hw_setup_three <= pwdata[7:0] & hw_setup_pkg::S3_WRITABLE;
    end
  end

  // events arriving in the read cycle survive the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_event_collect <= hw_setup_pkg::EVENT_RST;
      sleep_q <= 1'b0;
      flags <= '0;
    end else begin
      pin_event_collect <= next_events;
      sleep_q <= sleeping;
      flags.encoder_out_ready_flag <= encoder_data_pending;
      flags.decoder_need_flag <= decoder_data_wanted;
      flags.phrase_queue_empty_flag <= phrase_wanted;
      flags.port_change_flag <= |next_events;
    end
  end

  // setup fields to the pins' control logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else begin
      cfg.serial_out_drive_sel <= hw_setup_zero[hw_setup_pkg::S0_SDX_DRV];
      cfg.irq_pin_drive_sel <= hw_setup_zero[hw_setup_pkg::S0_IRQ_DRV];
      cfg.flash_ready_pullup_off <= hw_setup_zero[hw_setup_pkg::S0_FLASH_PU];
      cfg.serial_link_drive_sel <= hw_setup_zero[hw_setup_pkg::S0_LINK_DRV];
      cfg.aux_crystal_enable <= hw_setup_zero[hw_setup_pkg::S0_AUX_CRYSTAL_FREQ_SEL];
      cfg.calendar_enable <= hw_setup_zero[hw_setup_pkg::S0_CALENDAR];
      cfg.conv_clk_src_sel <= hw_setup_zero[hw_setup_pkg::S0_CONV_SRC];
      cfg.aux_port_mode <= hw_setup_pkg::port_mode_t'(hw_setup_one[7:6]);
      cfg.conv_clk_tracking <= hw_setup_one[5];
      cfg.conv_rate_double <= hw_setup_one[4];
      cfg.master_sync_sel <= hw_setup_one[3];
      cfg.crystal_freq_sel <= hw_setup_one[2:1];
      cfg.alt_serial_sel <= hw_setup_one[0];
      cfg.mem_pin_drive_sel <= hw_setup_two[7];
      cfg.tx_edge_sel <= hw_setup_two[6];
      cfg.rx_edge_sel <= hw_setup_two[5];
      cfg.refresh_rate <= hw_setup_two[1:0];
      cfg.slow_crystal_mode <= hw_setup_three[4];
      cfg.serial_flash_sel <= hw_setup_three[3];
      cfg.mixed_port_sel <= hw_setup_three[2];
    end
  end

  chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready) |=> pready) else $error("pready late");
  chk_sleep_read: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping |=> setup0_view[0]) else $error("sleep bit wrong");
  chk_sleep_low: assert property (@(posedge pclk) disable iff (!presetn)
    !sleeping |=> !setup0_view[0]) else $error("sleep bit set while active");
  // the stored copy of the sleep bit can never be written by software
  chk_sleep_stored: assert property (@(posedge pclk) disable iff (!presetn)
    hw_setup_zero[hw_setup_pkg::S0_SLEEP] == 1'b0) else $error("sleep bit writable");
  chk_event_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_read && port_match == 16'h0000) |=> pin_event_collect == 16'h0000)
    else $error("event not cleared");
  chk_port_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (|port_match) |=> flags.port_change_flag) else $error("port flag mismatch");
  chk_port_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (ev_read && port_match == 16'h0000) |=> !flags.port_change_flag)
    else $error("port flag not cleared");
  chk_port_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (flags.port_change_flag && !ev_read) |=> flags.port_change_flag)
    else $error("port flag dropped");
  chk_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
    hw_setup_two[4:2] == 3'b000 && hw_setup_three[7:5] == 3'b000
    && hw_setup_three[1:0] == 2'b00) else $error("fixed zero bit set");
  chk_wake_default: assert property (@(posedge pclk) disable iff (!presetn)
    wake_up |=> hw_setup_one == hw_setup_pkg::SETUP1_RST) else $error("wake not reset");
  chk_wake_all: assert property (@(posedge pclk) disable iff (!presetn)
    wake_up |=> hw_setup_zero == hw_setup_pkg::SETUP0_RST
    && hw_setup_two == hw_setup_pkg::SETUP2_RST
    && hw_setup_three == hw_setup_pkg::SETUP3_RST) else $error("wake not reset all");
  chk_data_flags: assert property (@(posedge pclk) disable iff (!presetn)
    encoder_data_pending |=> flags.encoder_out_ready_flag) else $error("data flag");
  chk_dec_flag: assert property (@(posedge pclk) disable iff (!presetn)
    decoder_data_wanted |=> flags.decoder_need_flag) else $error("decoder flag");
  chk_flags_low: assert property (@(posedge pclk) disable iff (!presetn)
    (!encoder_data_pending && !decoder_data_wanted) |=>
    (!flags.encoder_out_ready_flag && !flags.decoder_need_flag)) else $error("data flag stuck");
  // error answers only ever travel with the ready pulse
  chk_err_pair: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("error without ready");
  chk_status_wr: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit_st && !pready) |=> pslverr) else $error("status write accepted");
  chk_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000) else $error("read data outside answer");
  chk_drive_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit0 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.serial_out_drive_sel == $past(pwdata[7], 2)) else $error("drive select");
  chk_pullup_sense: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit0 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.flash_ready_pullup_off == $past(pwdata[5], 2)) else $error("pull-up select");
  chk_crystal_freq_sel_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit1 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.crystal_freq_sel == $past(pwdata[2:1], 2)) else $error("crystal field");
  chk_refresh_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit2 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.refresh_rate == $past(pwdata[1:0], 2)) else $error("refresh field");
  chk_flash_sel: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit3 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.serial_flash_sel == $past(pwdata[3], 2)) else $error("flash select");
  chk_phrase_flag: assert property (@(posedge pclk) disable iff (!presetn)
    phrase_wanted |=> flags.phrase_queue_empty_flag) else $error("phrase flag");
  chk_mode_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && hit1 && !pready && !wake_up ##1 !wake_up) |=>
    cfg.aux_port_mode == hw_setup_pkg::port_mode_t'($past(pwdata[7:6], 2)))
    else $error("mode field");
endmodule

// ---- apb_host.sv ----
// bus master model standing in for the host controller
// assumes a registered slave answer on the shared pclk
`timescale 1ns/1ps
module apb_host (
  // clock and slave answer
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    // stale data must not look valid once released
    pwdata <= ~d;
  endtask
endmodule

// ---- hw_config_status_regs_tb.sv ----
// self-checking bench for the hardware setup register bank
// assumes apb_host as the only master on the register port
`timescale 1ns/1ps
module hw_config_status_regs_tb;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, ec;
  logic encoder_data_pending, decoder_data_wanted, phrase_wanted, sleeping, wake_up;
  logic [15:0] port_match;
  hw_setup_pkg::hw_cfg_t cfg;
  hw_setup_pkg::status_flags_t flags;
  logic [7:0] st = hw_setup_pkg::ADDR_STATUS;
  logic [7:0] s0 = hw_setup_pkg::ADDR_SETUP0;
  logic [7:0] sh [4] = '{default: 8'h00};
  // rows cycle over setup0..3: written byte, then byte read back
  logic [15:0] rows [16] = '{16'hFFFE, 16'hA5A5, 16'hFFE3, 16'hFF1C, 16'h0000, 16'h5A5A,
    16'h1C00, 16'hE300, 16'h5554, 16'h0000, 16'h4141, 16'h1414, 16'hAAAA, 16'h3131, 16'h8282, 16'h0808};
  int mismatches = 0;
  int cmp_count = 0;
  hw_config_status_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .encoder_data_pending(encoder_data_pending), .wake_up(wake_up),
    .decoder_data_wanted(decoder_data_wanted), .phrase_wanted(phrase_wanted),
    .port_match(port_match), .sleeping(sleeping), .cfg(cfg), .flags(flags));
  apb_host u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] ad, input logic [31:0] exp);
    u_host.xfer(1'b0, ad, 32'h0, rd, err);
    chk(what, exp, rd);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #10 pclk = ~pclk;
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0;
    {encoder_data_pending, decoder_data_wanted, phrase_wanted, sleeping, wake_up, port_match} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 6; k++) rd_chk("reset value", st + 8'(4 * k), 32'h0);
    for (int i = 0; i < 16; i++) begin
      a = s0 + 8'(4 * (i % 4));
      u_host.xfer(1'b1, a, {24'h0, rows[i][15:8]}, rd, err);
      rd_chk("setup readback", a, {24'h0, rows[i][7:0]});
      sh[i % 4] = rows[i][7:0];
      ec = {9'h0, sh[0][7:1], sh[1], sh[2][7:5], sh[2][1:0], sh[3][4:2]};
      chk("cfg", ec, {9'h0, cfg});
    end
    sleeping <= 1'b1;
    rd_chk("sleep bit", s0, 32'hAB);
    {decoder_data_wanted, phrase_wanted} <= 2'b11;
    rd_chk("status dec phrase", st, 32'hA);
    chk("flag outputs", 32'h6, {28'h0, flags});
    {encoder_data_pending, decoder_data_wanted, phrase_wanted} <= 3'b100;
    rd_chk("status encoder", st, 32'h8);
    {encoder_data_pending, port_match} <= {1'b0, 16'h0020};
    @(posedge pclk);
    port_match <= 16'h0000;
    rd_chk("status port", st, 32'h1);
    rd_chk("event collect", hw_setup_pkg::ADDR_EVENT, 32'h20);
    rd_chk("status cleared", st, 32'h0);
    u_host.xfer(1'b1, st, 32'hFF, rd, err);
    chk("status write refused", 32'h1, {31'h0, err});
    u_host.xfer(1'b0, 8'h40, 32'h0, rd, err);
    chk("unmapped refused", 32'h1, {31'h0, err});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("reset reload", s0 + 8'h0C, 32'h0);
    u_host.xfer(1'b1, s0 + 8'h0C, 32'h08, rd, err);
    rd_chk("pre-wake value", s0 + 8'h0C, 32'h08);
    wake_up <= 1'b1;
    @(posedge pclk);
    wake_up <= 1'b0;
    rd_chk("wake reload", s0 + 8'h0C, 32'h0);
    end_of_test();
  end
endmodule
